/* verilog/vcr_pkg.sv */
// constants and types shared by the violation counter readback block
package vcr_pkg;
  localparam int unsigned NUM_CH = 14;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ADR_W = 12;
  // printed register indices; byte address is four times the index
  localparam logic [ADR_W-1:0] IDX_CTRL = 12'h0e6;
  localparam logic [ADR_W-1:0] IDX_SPARE = 12'h0e7;
  localparam logic [ADR_W-1:0] IDX_BYTE = 12'h0e8;
  localparam logic [ADR_W-1:0] ADR_CTRL = 12'h398;
  localparam logic [ADR_W-1:0] ADR_SPARE = 12'h39c;
  localparam logic [ADR_W-1:0] ADR_BYTE = 12'h3a0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_CLR = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
  localparam logic [SEL_W-1:0] SEL_LAST = 4'he;
  // minimum hold of a clear bit, kept by software
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned CLR_MIN_NS = 1000;
  localparam int unsigned CLR_MIN_CYC = (CLR_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [2:0] spare;
    logic clear_every_counter;
    logic snapshot_every_counter;
    logic readout_half_select;
    logic snapshot_one_channel;
    logic clear_one_channel;
  } vcr_ctrl_t;
endpackage

/* verilog/vcr_counter_bank.sv */
// wishbone register bank with per channel violation counters and holding registers
// Function
// - clear-all bit held high clears every channel counter to zero; host holds 1 us.
// - rising snapshot-all bit copies all fourteen counters into holding registers.
// - half-select bit picks low byte (zero, default) or high byte for readout.
// - rising per-channel snapshot copies only the selected channel's counter.
// - per-channel clear bit clears only the selected channel's counter to zero.
// - per-channel clear, snapshot and readout use the four-bit channel selector.
// - eight-bit readout register shows chosen held byte of the addressed channel.
// - after reset readout shows zero (channel zero low byte), control reads zero.
// - upper three control bits and spare register are plain storage, reset zero.
// - selector 0000 is no channel, 0001 to 1110 are channels zero to thirteen.
// - each counter saturates at full scale until a clear resets it.
// - readout is available only while readback enable is set, else reads zero.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module vcr_counter_bank #(
  parameter int unsigned NUM_CH = vcr_pkg::NUM_CH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [vcr_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [vcr_pkg::SEL_W-1:0] counter_channel_select_i,
  input wire logic readback_enable_i,
  input wire logic [NUM_CH-1:0] line_code_violation_i
);

  vcr_pkg::vcr_ctrl_t ctrl_q;
  vcr_pkg::vcr_ctrl_t ctrl_prev_q;
  logic [7:0] spare_q;
  logic [7:0] held_count_byte_q;
  logic [vcr_pkg::CNT_W-1:0] cnt_q [NUM_CH];
  logic [vcr_pkg::CNT_W-1:0] hold_q [NUM_CH];
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_en;
  logic sel_valid;
  logic [vcr_pkg::SEL_W-1:0] ch_idx;
  logic snap_all_rise;
  logic snap_one_rise;

  assign req = cyc_i & stb_i;
  // writes land at the edge where the master sees ack
  assign wr_en = ce_i & req & ack_q & we_i & sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // channel decode: zero and 1111 mean none, 0001 to 1110 are offset by one
  assign sel_valid = (counter_channel_select_i != vcr_pkg::SEL_NONE) &&
                     (counter_channel_select_i <= vcr_pkg::SEL_LAST);
  assign ch_idx = counter_channel_select_i - 4'h1;

  // edge detect so a bit left at one does not keep refreshing the holding copy
  assign snap_all_rise = ctrl_q.snapshot_every_counter & ~ctrl_prev_q.snapshot_every_counter;
  assign snap_one_rise = ctrl_q.snapshot_one_channel & ~ctrl_prev_q.snapshot_one_channel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (ce_i && req && !ack_q) begin
      case (adr_i)
        vcr_pkg::ADR_CTRL: dat_q <= {24'h00_0000, ctrl_q};
        vcr_pkg::ADR_SPARE: dat_q <= {24'h00_0000, spare_q};
        vcr_pkg::ADR_BYTE: dat_q <= {24'h00_0000, held_count_byte_q};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= vcr_pkg::vcr_ctrl_t'(vcr_pkg::CTRL_RST);
    end else if (wr_en && adr_i == vcr_pkg::ADR_CTRL) begin
      ctrl_q <= vcr_pkg::vcr_ctrl_t'(dat_i[7:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_prev_q <= vcr_pkg::vcr_ctrl_t'(vcr_pkg::CTRL_RST);
    end else if (ce_i) begin
      ctrl_prev_q <= ctrl_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spare_q <= vcr_pkg::SPARE_RST;
    end else if (wr_en && adr_i == vcr_pkg::ADR_SPARE) begin
      spare_q <= dat_i[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic hit;
      localparam logic [vcr_pkg::SEL_W-1:0] CH_CODE = (vcr_pkg::SEL_W)'(g + 1);
      assign hit = sel_valid && (ch_idx == (vcr_pkg::SEL_W)'(g));

      // clears win over counting; counting stops at full scale
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q[g] <= vcr_pkg::CNT_CLR;
        end else if (ce_i) begin
          if (ctrl_q.clear_every_counter) begin
            cnt_q[g] <= vcr_pkg::CNT_CLR;
          end else if (ctrl_q.clear_one_channel && hit) begin
            cnt_q[g] <= vcr_pkg::CNT_CLR;
          end else if (line_code_violation_i[g] && cnt_q[g] != vcr_pkg::CNT_FULL) begin
            cnt_q[g] <= cnt_q[g] + 16'h0001;
          end
        end
      end

      // whole word copied in one cycle so both halves match
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hold_q[g] <= vcr_pkg::CNT_CLR;
        end else if (ce_i) begin
          if (snap_all_rise || (snap_one_rise && hit)) begin
            hold_q[g] <= cnt_q[g];
          end
        end
      end

      // per-channel clear and snapshot checks below key on the selector code itself; the count step check uses the decoded hit
      count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && line_code_violation_i[g] && !ctrl_q.clear_every_counter &&
        !(ctrl_q.clear_one_channel && hit) && cnt_q[g] != vcr_pkg::CNT_FULL |=>
        cnt_q[g] == $past(cnt_q[g]) + 16'h0001)
        else $error("counter did not advance on a violation");

      count_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !line_code_violation_i[g] && !ctrl_q.clear_every_counter &&
        !ctrl_q.clear_one_channel |=> cnt_q[g] == $past(cnt_q[g]))
        else $error("counter moved without a violation or a clear");

      clear_each_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ctrl_q.clear_every_counter |=> cnt_q[g] == vcr_pkg::CNT_CLR)
        else $error("clear-all missed a counter");

      clear_spare_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ctrl_q.clear_one_channel && counter_channel_select_i != CH_CODE &&
        !ctrl_q.clear_every_counter && !line_code_violation_i[g] |=>
        cnt_q[g] == $past(cnt_q[g]))
        else $error("per-channel clear touched an unselected counter");

      snap_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (snap_all_rise ||
        (snap_one_rise && counter_channel_select_i == CH_CODE)) |=>
        hold_q[g] == $past(cnt_q[g]))
        else $error("holding register did not take the whole count");

      snap_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !snap_all_rise &&
        !(snap_one_rise && counter_channel_select_i == CH_CODE) |=>
        hold_q[g] == $past(hold_q[g]))
        else $error("holding register changed without a snapshot");

      freeze_ch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> cnt_q[g] == $past(cnt_q[g]) && hold_q[g] == $past(hold_q[g]))
        else $error("channel state moved while the clock enable was low");

      count_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cnt_q[g] == vcr_pkg::CNT_FULL && !ctrl_q.clear_every_counter &&
        !ctrl_q.clear_one_channel |=> cnt_q[g] == vcr_pkg::CNT_FULL)
        else $error("a channel counter wrapped past full scale");
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_count_byte_q <= vcr_pkg::BYTE_RST;
    end else if (ce_i) begin
      if (!readback_enable_i || !sel_valid) begin
        held_count_byte_q <= 8'h00;
      end else if (ctrl_q.readout_half_select) begin
        held_count_byte_q <= hold_q[ch_idx][15:8];
      end else begin
        held_count_byte_q <= hold_q[ch_idx][7:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    ce_i && req && !ack_q;
  endsequence

  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence

  bus_answer_a: assert property (s_take ##1 ce_i |-> s_answer)
    else $error("ack did not pulse for one cycle after a request");

  clear_all_a: assert property (ce_i && ctrl_q.clear_every_counter |=>
    cnt_q[0] == vcr_pkg::CNT_CLR && cnt_q[NUM_CH-1] == vcr_pkg::CNT_CLR)
    else $error("clear-all left a counter nonzero");

  clear_one_a: assert property (ce_i && ctrl_q.clear_one_channel && sel_valid |=>
    cnt_q[$past(ch_idx)] == vcr_pkg::CNT_CLR)
    else $error("per-channel clear missed the selected counter");

  snap_all_a: assert property (ce_i && snap_all_rise |=>
    hold_q[0] == $past(cnt_q[0]) && hold_q[NUM_CH-1] == $past(cnt_q[NUM_CH-1]))
    else $error("snapshot-all did not copy the counters");

  snap_one_a: assert property (ce_i && snap_one_rise && sel_valid |=>
    hold_q[$past(ch_idx)] == $past(cnt_q[ch_idx]))
    else $error("channel snapshot did not copy the selected counter");

  snap_other_a: assert property (ce_i && !snap_all_rise && sel_valid && ch_idx != 4'h0 |=>
    hold_q[0] == $past(hold_q[0]))
    else $error("channel snapshot disturbed another channel");

  readout_half_a: assert property (ce_i && readback_enable_i && sel_valid |=>
    held_count_byte_q == ($past(ctrl_q.readout_half_select) ?
      $past(hold_q[ch_idx][15:8]) : $past(hold_q[ch_idx][7:0])))
    else $error("readout byte does not match the selected half");

  readout_off_a: assert property (ce_i && !readback_enable_i |=>
    held_count_byte_q == 8'h00)
    else $error("readout shown while readback is disabled");

  count_sat_a: assert property (ce_i && cnt_q[0] == vcr_pkg::CNT_FULL &&
    !ctrl_q.clear_every_counter && !ctrl_q.clear_one_channel |=>
    cnt_q[0] == vcr_pkg::CNT_FULL)
    else $error("counter left full scale without a clear");

  reset_value_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
    ctrl_q == vcr_pkg::vcr_ctrl_t'(vcr_pkg::CTRL_RST) && spare_q == 8'h00 &&
    held_count_byte_q == 8'h00 && !ack_o)
    else $error("register not at reset value after reset");

  sequence s_write_take;
    ce_i && req && ack_q && we_i;
  endsequence

  ack_once_a: assert property (ce_i && ack_o |=> !ack_o)
    else $error("ack stayed high for a second cycle");

  ack_cause_a: assert property (ack_o && $past(ce_i) |-> $past(req))
    else $error("ack without a request");

  read_ctrl_a: assert property (s_take ##0 (adr_i == vcr_pkg::ADR_CTRL) |=>
    dat_o == {24'h00_0000, $past(ctrl_q)})
    else $error("control register read back wrong");

  read_spare_a: assert property (s_take ##0 (adr_i == vcr_pkg::ADR_SPARE) |=>
    dat_o == {24'h00_0000, $past(spare_q)})
    else $error("spare register read back wrong");

  read_byte_a: assert property (s_take ##0 (adr_i == vcr_pkg::ADR_BYTE) |=>
    dat_o == {24'h00_0000, $past(held_count_byte_q)})
    else $error("readout register read back wrong");

  read_unmapped_a: assert property (s_take ##0 (adr_i != vcr_pkg::ADR_CTRL &&
    adr_i != vcr_pkg::ADR_SPARE && adr_i != vcr_pkg::ADR_BYTE) |=> dat_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  write_ctrl_a: assert property (s_write_take ##0
    (sel_i[0] && adr_i == vcr_pkg::ADR_CTRL) |=>
    ctrl_q == vcr_pkg::vcr_ctrl_t'($past(dat_i[7:0])))
    else $error("control write did not land");

  write_spare_a: assert property (s_write_take ##0
    (sel_i[0] && adr_i == vcr_pkg::ADR_SPARE) |=>
    spare_q == $past(dat_i[7:0]))
    else $error("spare write did not land");

  // a write with lane zero off must leave every stored byte alone
  write_masked_a: assert property (s_write_take ##0 !sel_i[0] |=>
    ctrl_q == $past(ctrl_q) && spare_q == $past(spare_q))
    else $error("write with byte lane zero off changed a register");

  store_keep_a: assert property (!(ce_i && req && ack_q && we_i) |=>
    ctrl_q == $past(ctrl_q) && spare_q == $past(spare_q))
    else $error("register changed without a write");

  readout_none_a: assert property (ce_i &&
    counter_channel_select_i == vcr_pkg::SEL_NONE |=> held_count_byte_q == 8'h00)
    else $error("readout shown with no channel selected");

  freeze_bus_a: assert property (!ce_i |=>
    ack_o == $past(ack_o) && dat_o == $past(dat_o) && ctrl_q == $past(ctrl_q) &&
    held_count_byte_q == $past(held_count_byte_q))
    else $error("bus state moved while the clock enable was low");

  reset_count_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
    cnt_q[0] == vcr_pkg::CNT_CLR && hold_q[0] == vcr_pkg::CNT_CLR && dat_o == 32'h0000_0000)
    else $error("counter state not cleared after reset");

endmodule // vcr_counter_bank

/* verif/vcr_counter_bank_tb.sv */
// self-checking bench for the violation counter readback bank
`timescale 1ns/10ps
module vcr_counter_bank_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] wsel = 4'hf;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [vcr_pkg::ADR_W-1:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [vcr_pkg::SEL_W-1:0] counter_channel_select_i = '0;
  logic readback_enable_i = 1'b0;
  logic [13:0] line_code_violation_i = '0;
  logic [7:0] exp_q[$];
  logic [7:0] rv;
  int fails = 0;
  int checks_done = 0;
  int ch;
  int oc;
  int n;

  vcr_counter_bank dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .counter_channel_select_i(counter_channel_select_i), .readback_enable_i(readback_enable_i),
    .line_code_violation_i(line_code_violation_i));

  initial forever #5 clk_i = ~clk_i;

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one classic cycle; a read leaves its expected byte on the queue
  task automatic wb(input logic w, input logic [vcr_pkg::ADR_W-1:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    if (!w) exp_q.push_back(d);
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      $display("unexpected at %0t: no ack from the bank", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // snapshot bits act on a rising edge, so lower first; readout lags the copy
  task automatic snap(input logic [7:0] c);
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'h00);
    wb(1'b1, vcr_pkg::ADR_CTRL, c);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic clr(input logic [7:0] c);
    wb(1'b1, vcr_pkg::ADR_CTRL, c);
    repeat (vcr_pkg::CLR_MIN_CYC) @(posedge clk_i);
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'h00);
  endtask

  task automatic pulse(input logic [13:0] m, input int cnt);
    @(posedge clk_i);
    line_code_violation_i <= m;
    repeat (cnt) @(posedge clk_i);
    line_code_violation_i <= '0;
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      checks_done++;
      if (dat_o !== {24'h000000, exp_q[0]}) begin
        fails++;
        $display("unexpected at %0t: read %h, wanted %h", $time, dat_o, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(19230));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, vcr_pkg::ADR_CTRL, 8'h00);
    wb(1'b0, vcr_pkg::ADR_SPARE, 8'h00);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    wb(1'b0, 12'h004, 8'h00);
    rv = 8'($urandom);
    wb(1'b1, vcr_pkg::ADR_SPARE, rv);
    wb(1'b0, vcr_pkg::ADR_SPARE, rv);
    // lane zero off: the write must be ignored
    wsel = 4'he;
    wb(1'b1, vcr_pkg::ADR_SPARE, ~rv);
    wsel = 4'hf;
    wb(1'b0, vcr_pkg::ADR_SPARE, rv);
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'he0);
    wb(1'b0, vcr_pkg::ADR_CTRL, 8'he0);
    ch = $urandom % 14;
    oc = (ch + 1) % 14;
    n = 3 + $urandom % 20;
    pulse((14'h0001 << ch) | (14'h0001 << oc), n);
    counter_channel_select_i <= 4'(ch + 1);
    readback_enable_i <= 1'b1;
    snap(8'h02);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'(n));
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'h04);
    repeat (3) @(posedge clk_i);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    counter_channel_select_i <= 4'(oc + 1);
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'h00);
    repeat (3) @(posedge clk_i);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    snap(8'h08);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'(n));
    readback_enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    readback_enable_i <= 1'b1;
    counter_channel_select_i <= vcr_pkg::SEL_NONE;
    repeat (3) @(posedge clk_i);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    counter_channel_select_i <= 4'(ch + 1);
    clr(8'h01);
    snap(8'h02);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    counter_channel_select_i <= 4'(oc + 1);
    snap(8'h08);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'(n));
    clr(8'h10);
    snap(8'h08);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    // violations while the clock enable is low must not count
    ce_i <= 1'b0;
    pulse(14'h0001 << oc, 5);
    ce_i <= 1'b1;
    snap(8'h08);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'h00);
    // long enough to pass full scale by a margin
    pulse(14'h0001 << oc, 66000);
    snap(8'h08);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'hff);
    wb(1'b1, vcr_pkg::ADR_CTRL, 8'h04);
    repeat (3) @(posedge clk_i);
    wb(1'b0, vcr_pkg::ADR_BYTE, 8'hff);
    repeat (3) @(posedge clk_i);
    conclude();
  end
endmodule // vcr_counter_bank_tb
